// ### rtl/crp_pkg.sv
// Package with constants and carrier types for the clock, reset and interrupt pin front end.
package crp_pkg;
    localparam int unsigned CRP_CLK_HZ = 20000000;
    localparam int unsigned CRP_OSC_DIV = 4;
    localparam int unsigned CRP_INT_RESET_PHASES = 2;
    localparam logic [3:0] CRP_PHASE_LAST = 4'h7;
    localparam logic [3:0] CRP_RESET_HOLD = 4'hF;
    localparam logic CRP_QUAD_EN_RESET = 1'b1;
    localparam logic CRP_EDGE_SEL_RESET = 1'b0;
    localparam logic CRP_BUS_CLK_EN_RESET = 1'b1;

    typedef struct packed {
        logic quad_clock_enable_bit;
        logic interrupt_edge_select;
        logic bus_clk_pin_enable;
        logic single_chip_mode;
    } crp_cfg_t;

    typedef struct packed {
        logic watchdog_monitor_fail;
        logic clock_monitor_fail;
    } crp_fail_t;

    typedef enum logic [1:0] {
        CRP_RST_IDLE = 2'b00,
        CRP_RST_DRIVE = 2'b01,
        CRP_RST_WATCH = 2'b10
    } crp_rst_state_t;
endpackage

// ### rtl/crp_sync2.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module crp_sync2 #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // The first stage is read only by the second stage.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else if (en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ### rtl/crp_clock_reset_irq.sv
// Clock divider, open-drain reset pin logic and maskable interrupt front end.
`timescale 1ns/1ps
// Contract
// - Bus clock is oscillator divided by four.
// - Bus clock low processes, high accesses.
// - Stop mode halts every clock output.
// - Bus clock pin can turn off single-chip.
// - Quad-rate output runs four times bus clock.
// - Quad output enabled at reset, bit disables.
// - Low reset pin resets whole device.
// - Failures pull reset low, never high.
// - Fast pin rise means internal reset.
// - Interrupt selectable falling edge or low level.
// - Interrupt level-triggered out of reset.
// - Low line re-interrupts once mask clears.
module crp_clock_reset_irq (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic stop_mode,
    input wire crp_pkg::crp_cfg_t cfg,
    input wire crp_pkg::crp_fail_t fail,
    input wire logic reset_pin_in,
    input wire logic irq_pin_n,
    input wire logic irq_mask,
    input wire logic irq_ack,
    output logic bus_phase_clk,
    output logic bus_clk_pin,
    output logic quad_rate_clock_out,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic device_reset,
    output logic reset_was_internal,
    output logic irq_request
);
    // The quad output is the oscillator reference at half the core rate, so a bus
    // cycle spans eight core cycles and the quad output runs four times the bus clock.
    localparam int unsigned CORE_PER_OSC = 2;
    localparam int unsigned WATCH_CYCLES =
        crp_pkg::CRP_INT_RESET_PHASES * crp_pkg::CRP_OSC_DIV * CORE_PER_OSC;

    logic [3:0] phase_reg;
    logic [3:0] phase_next;
    logic [3:0] hold_reg;
    logic [3:0] watch_reg;
    logic reset_sync;
    logic irq_sync;
    logic irq_prev_reg;
    logic edge_latch_reg;
    logic clk_run;
    logic phase_wrap;
    logic fail_any;
    logic ext_low;
    logic irq_fall;
    logic irq_cond;
    logic watch_expired;
    crp_pkg::crp_rst_state_t state_reg;
    crp_pkg::crp_rst_state_t state_next;

    crp_sync2 #(.RESET_VALUE(1'b1)) u_sync_reset (
        .core_clk(core_clk),
        .rst(rst),
        .en(clk_en),
        .async_in(reset_pin_in),
        .sync_out(reset_sync)
    );

    crp_sync2 #(.RESET_VALUE(1'b1)) u_sync_irq (
        .core_clk(core_clk),
        .rst(rst),
        .en(clk_en),
        .async_in(irq_pin_n),
        .sync_out(irq_sync)
    );

    // Clocks stall in stop mode so no clock output toggles until it is left.
    assign clk_run = clk_en && !stop_mode;
    assign phase_wrap = (phase_reg == crp_pkg::CRP_PHASE_LAST);
    assign phase_next = phase_wrap ? 4'h0 : phase_reg + 4'h1;
    assign fail_any = fail.watchdog_monitor_fail || fail.clock_monitor_fail;
    assign ext_low = !reset_sync && (state_reg == crp_pkg::CRP_RST_IDLE);
    assign watch_expired = (watch_reg == 4'(WATCH_CYCLES - 1));
    assign irq_fall = irq_prev_reg && !irq_sync;
    // Level mode follows the synchronised line, so a line still low re-requests after unmask.
    assign irq_cond = cfg.interrupt_edge_select ? edge_latch_reg : !irq_sync;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            crp_pkg::CRP_RST_IDLE: begin
                if (fail_any) begin
                    state_next = crp_pkg::CRP_RST_DRIVE;
                end else if (!reset_sync) begin
                    state_next = crp_pkg::CRP_RST_WATCH;
                end
            end
            crp_pkg::CRP_RST_DRIVE: begin
                if (hold_reg == crp_pkg::CRP_RESET_HOLD) begin
                    state_next = crp_pkg::CRP_RST_WATCH;
                end
            end
            crp_pkg::CRP_RST_WATCH: begin
                // Stay until the pin is high so a long external reset is never re-watched.
                if (reset_sync) begin
                    state_next = crp_pkg::CRP_RST_IDLE;
                end
            end
            default: begin
                state_next = crp_pkg::CRP_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 4'h0;
            bus_phase_clk <= 1'b0;
            bus_clk_pin <= 1'b0;
            quad_rate_clock_out <= 1'b0;
        end else if (clk_run) begin
            phase_reg <= phase_next;
            // Low for phases 0-3 (internal work), high for 4-7 (data access).
            bus_phase_clk <= phase_next[2];
            bus_clk_pin <= phase_next[2] && (cfg.bus_clk_pin_enable || !cfg.single_chip_mode);
            quad_rate_clock_out <= cfg.quad_clock_enable_bit && !quad_rate_clock_out;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= crp_pkg::CRP_RST_IDLE;
            hold_reg <= 4'h0;
            watch_reg <= 4'h0;
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b0;
            device_reset <= 1'b1;
            reset_was_internal <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            hold_reg <= (state_reg == crp_pkg::CRP_RST_DRIVE) ? hold_reg + 4'h1 : 4'h0;
            if (state_reg != crp_pkg::CRP_RST_WATCH) begin
                watch_reg <= 4'h0;
            end else if (!watch_expired) begin
                watch_reg <= watch_reg + 4'h1;
            end
            // Open drain: the output level is always low, only the enable moves.
            reset_pin_out <= 1'b0;
            reset_pin_oe <= (state_next == crp_pkg::CRP_RST_DRIVE);
            device_reset <= (state_next != crp_pkg::CRP_RST_IDLE) || ext_low;
            if (state_reg == crp_pkg::CRP_RST_WATCH && state_next == crp_pkg::CRP_RST_IDLE) begin
                // A slow RC rise lands here as external, which is why it is discouraged.
                reset_was_internal <= !watch_expired;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_prev_reg <= 1'b1;
            edge_latch_reg <= 1'b0;
            irq_request <= 1'b0;
        end else if (clk_en) begin
            irq_prev_reg <= irq_sync;
            // A new edge wins over an acknowledge in the same cycle.
            edge_latch_reg <= irq_fall || (edge_latch_reg && !irq_ack);
            irq_request <= irq_cond && !irq_mask && !device_reset;
        end
    end

    AST_DIV_FOUR: assert property (@(posedge core_clk) disable iff (rst)
        clk_run && phase_reg == 4'h3
        |=> bus_phase_clk) else $error("bus clock not high in access half");
    AST_LOW_HALF: assert property (@(posedge core_clk) disable iff (rst)
        phase_reg < 4'h4 |-> !bus_phase_clk) else $error("bus clock high in process half");
    AST_STOP_FREEZE: assert property (@(posedge core_clk) disable iff (rst)
        stop_mode |=> $stable(bus_phase_clk) && $stable(quad_rate_clock_out))
        else $error("clock moved in stop mode");
    AST_PIN_OFF: assert property (@(posedge core_clk) disable iff (rst)
        cfg.single_chip_mode && !cfg.bus_clk_pin_enable && clk_run |=> !bus_clk_pin)
        else $error("bus clock pin ran while off");
    AST_QUAD_TOGGLE: assert property (@(posedge core_clk) disable iff (rst)
        clk_run && cfg.quad_clock_enable_bit && !quad_rate_clock_out |=> quad_rate_clock_out)
        else $error("quad clock did not toggle");
    AST_QUAD_OFF: assert property (@(posedge core_clk) disable iff (rst)
        clk_run && !cfg.quad_clock_enable_bit |=> !quad_rate_clock_out)
        else $error("quad clock driven while disabled");
    AST_EXT_RESET: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && ext_low |=> device_reset) else $error("external reset missed");
    AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (rst)
        reset_pin_oe |-> !reset_pin_out) else $error("reset pin driven high");
    AST_FAIL_PULL: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && fail_any && state_reg == crp_pkg::CRP_RST_IDLE |=> reset_pin_oe)
        else $error("failure did not pull reset");
    AST_CLASSIFY: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state_reg == crp_pkg::CRP_RST_WATCH && watch_expired && reset_sync
        |=> !reset_was_internal) else $error("slow rise taken as internal");
    AST_LEVEL_IRQ: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !cfg.interrupt_edge_select && !irq_sync && !irq_mask && !device_reset
        |=> irq_request) else $error("low level did not interrupt");
    AST_SYNC_DELAY: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && $fell(irq_sync) |-> $past(irq_pin_n, 2) == 1'b0)
        else $error("interrupt pin not synchronised");
    AST_EDGE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && irq_fall |=> edge_latch_reg) else $error("edge lost");

    COV_INT_RESET: cover property (@(posedge core_clk) $rose(reset_was_internal));
    COV_EDGE_IRQ: cover property (@(posedge core_clk)
        cfg.interrupt_edge_select && $rose(irq_request));
    COV_STOP: cover property (@(posedge core_clk) $rose(stop_mode));
    COV_QUAD_OFF: cover property (@(posedge core_clk) $fell(cfg.quad_clock_enable_bit));
endmodule

// ### verification/crp_far_side.sv
// Far-side model: reset circuit with pull-up and a latched interrupt source.
`timescale 1ns/1ps
module crp_far_side (
    input wire logic core_clk,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic ext_hold,
    input wire logic slow_rise,
    input wire logic irq_raise,
    input wire logic irq_clear,
    output logic reset_line,
    output logic irq_line
);
    int charge_cnt = 0;
    logic irq_pend = 1'b0;
    // A slow rise stands for an RC network that outlasts the classification window.
    always @(posedge core_clk) begin
        if (reset_pin_oe || ext_hold) begin
            charge_cnt <= slow_rise ? 24 : 0;
        end else if (charge_cnt != 0) begin
            charge_cnt <= charge_cnt - 1;
        end
        if (irq_raise) begin
            irq_pend <= 1'b1;
        end else if (irq_clear) begin
            irq_pend <= 1'b0;
        end
    end
    // Open-drain wire with pull-up: any driver low wins.
    assign reset_line = !((reset_pin_oe && !reset_pin_out) || ext_hold || charge_cnt != 0);
    assign irq_line = !irq_pend;
endmodule

// ### verification/crp_clock_reset_irq_bench.sv
// Self-checking bench for the clock, reset and interrupt pin front end.
`timescale 1ns/1ps
module crp_clock_reset_irq_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic stop_mode = 1'b0;
    crp_pkg::crp_cfg_t cfg = 4'hA;
    crp_pkg::crp_fail_t fail = 2'h0;
    logic irq_mask = 1'b0;
    logic irq_ack = 1'b0;
    logic ext_hold = 1'b0;
    logic slow_rise = 1'b0;
    logic irq_raise = 1'b0;
    logic irq_clear = 1'b0;
    logic reset_line, irq_line, bus_phase_clk, bus_clk_pin, quad_out;
    logic reset_pin_out, reset_pin_oe, device_reset, reset_was_internal, irq_request;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'h21f3e028;
    int f, k;
    logic b, qv;
    logic bq[$];
    logic qq[$];

    crp_far_side far (.core_clk(core_clk), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .ext_hold(ext_hold), .slow_rise(slow_rise),
        .irq_raise(irq_raise), .irq_clear(irq_clear), .reset_line(reset_line),
        .irq_line(irq_line));
    crp_clock_reset_irq DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .stop_mode(stop_mode), .cfg(cfg), .fail(fail), .reset_pin_in(reset_line),
        .irq_pin_n(irq_line), .irq_mask(irq_mask), .irq_ack(irq_ack),
        .bus_phase_clk(bus_phase_clk), .bus_clk_pin(bus_clk_pin),
        .quad_rate_clock_out(quad_out), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .device_reset(device_reset),
        .reset_was_internal(reset_was_internal), .irq_request(irq_request));

    initial forever #25 core_clk = ~core_clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Run time is a few hundred cycles, so this ceiling only trips on a hang.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic pulse_fail(input crp_pkg::crp_fail_t v);
        fail <= v;
        cyc(1);
        fail <= 2'h0;
        for (k = 0; k < 5 && reset_pin_oe !== 1'b1; k++) cyc(1);
        chk("reset_pin_oe", 1'b1, reset_pin_oe);
        chk("reset_pin_out", 1'b0, reset_pin_out);
        for (k = 0; k < 40 && reset_pin_oe !== 1'b0; k++) cyc(1);
        for (k = 0; k < 60 && device_reset !== 1'b0; k++) cyc(1);
    endtask

    initial begin
        cyc(10);
        rst <= 1'b0;
        cyc(4);
        chk("device_reset", 1'b0, device_reset);
        for (k = 0; k < 16; k++) begin
            cyc(1);
            bq.push_back(bus_phase_clk);
            qq.push_back(quad_out);
        end
        f = 1;
        while (f < 12 && !(bq[f] === 1'b1 && bq[f-1] === 1'b0)) f++;
        for (k = f; k < 16; k++) chk("bus_phase_clk", ((k - f) % 8) < 4, bq[k]);
        for (k = 1; k < 16; k++) chk("quad_rate_clock_out", ~qq[k-1], qq[k]);
        stop_mode <= 1'b1;
        cyc(2);
        b = bus_phase_clk;
        qv = quad_out;
        cyc(6);
        chk("bus_phase_clk", b, bus_phase_clk);
        chk("quad_rate_clock_out", qv, quad_out);
        stop_mode <= 1'b0;
        cfg <= 4'h9;
        cyc(3);
        for (k = 0; k < 8; k++) begin
            cyc(1);
            chk("bus_clk_pin", 1'b0, bus_clk_pin);
        end
        cfg <= 4'h2;
        cyc(3);
        for (k = 0; k < 4; k++) begin
            cyc(1);
            chk("quad_rate_clock_out", 1'b0, quad_out);
        end
        cfg <= 4'hA;
        irq_raise <= 1'b1;
        cyc(1);
        irq_raise <= 1'b0;
        cyc(5);
        chk("irq_request", 1'b1, irq_request);
        irq_mask <= 1'b1;
        cyc(3);
        chk("irq_request", 1'b0, irq_request);
        cyc(2 + ($random(seed) & 7));
        irq_mask <= 1'b0;
        cyc(3);
        chk("irq_request", 1'b1, irq_request);
        irq_clear <= 1'b1;
        cyc(1);
        irq_clear <= 1'b0;
        cyc(5);
        chk("irq_request", 1'b0, irq_request);
        cfg <= 4'hE;
        cyc(2);
        irq_raise <= 1'b1;
        cyc(1 + ($random(seed) & 3));
        irq_raise <= 1'b0;
        irq_clear <= 1'b1;
        cyc(1);
        irq_clear <= 1'b0;
        cyc(6);
        chk("irq_request", 1'b1, irq_request);
        irq_ack <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        cyc(3);
        chk("irq_request", 1'b0, irq_request);
        cfg <= 4'hA;
        pulse_fail(2'h1);
        chk("reset_was_internal", 1'b1, reset_was_internal);
        ext_hold <= 1'b1;
        cyc(40);
        chk("device_reset", 1'b1, device_reset);
        chk("reset_pin_oe", 1'b0, reset_pin_oe);
        ext_hold <= 1'b0;
        for (k = 0; k < 30 && device_reset !== 1'b0; k++) cyc(1);
        chk("reset_was_internal", 1'b0, reset_was_internal);
        slow_rise <= 1'b1;
        pulse_fail(2'h2);
        chk("reset_was_internal", 1'b0, reset_was_internal);
        stop_test();
    end
endmodule
